// ### hw/fbw_map.svh
// Opcodes, register offsets, field positions and reset values
`ifndef FBW_MAP_SVH
`define FBW_MAP_SVH
// Serial opcodes
`define FBW_OP_WEL_SET     8'h06
`define FBW_OP_WEL_CLR     8'h04
`define FBW_OP_STAT_WR     8'h01
`define FBW_OP_FUNC_WR     8'h42
`define FBW_OP_ERASE_ALL_A 8'hC7
`define FBW_OP_ERASE_ALL_B 8'h60
`define FBW_OP_VOL_PARAM   8'hC0
`define FBW_OP_VOL_BANK    8'h17
`define FBW_OP_PP          8'h02
`define FBW_OP_PP4         8'h12
`define FBW_OP_PPQ         8'h32
`define FBW_OP_SE_A        8'h20
`define FBW_OP_SE_B        8'hD7
`define FBW_OP_SE4         8'h21
`define FBW_OP_BE32        8'h52
`define FBW_OP_BE32_4      8'h5C
`define FBW_OP_BE64        8'hD8
`define FBW_OP_BE64_4      8'hDC
// Frame lengths in serial bits
`define FBW_BITS_OP        6'd8
`define FBW_BITS_BYTE      6'd16
`define FBW_BITS_ADDR      6'd40
// Status and function byte field positions
`define FBW_SB_BP_LO       2
`define FBW_SB_QE          6
`define FBW_SB_STATUS_WRITE_DISABLE        7
`define FBW_FB_TBS         1
// AXI4-Lite register byte offsets
`define FBW_REG_STATUS     4'h0
`define FBW_REG_FUNC       4'h4
`define FBW_REG_GEOM       4'h8
`define FBW_REG_LAST       4'hC
// Geometry block counts
`define FBW_BLK_64K        13'h0800
`define FBW_BLK_256K       13'h0200
// Reset values and bus response codes
`define FBW_RST_BP         4'h0
`define FBW_RST_GEOM       1'b0
`define FBW_RESP_OK        2'b00
`define FBW_RESP_ERR       2'b10
`endif

// ### hw/fbw_pkg.sv
// Types shared by the block write protection logic
package fbw_pkg;
  // Command classes after decode
  typedef enum logic [7:0] {
    FBW_K_NONE = 8'h01,
    FBW_K_WSET = 8'h02,
    FBW_K_WCLR = 8'h04,
    FBW_K_STAT = 8'h08,
    FBW_K_FUNC = 8'h10,
    FBW_K_CHIP = 8'h20,
    FBW_K_PROG = 8'h40,
    FBW_K_VOL  = 8'h80
  } fbw_kind_e;

  // Whole state of the block
  typedef struct packed {
    logic [1:0]  sck_s;
    logic [1:0]  cs_s;
    logic [1:0]  si_s;
    logic [1:0]  wp_s;
    logic [1:0]  hold_s;
    logic        sck_p;
    logic        cs_p;
    logic [5:0]  cnt;
    logic [7:0]  op;
    logic [31:0] pay;
    logic [3:0]  bp;
    logic        qe;
    logic        status_write_disable;
    logic        wel;
    logic        top_bottom_select;
    logic        g256;
    logic [7:0]  last_op;
    logic        last_ok;
    logic        last_ref;
    logic        array_go;
    logic        erase_all;
    logic        refused;
    logic        vol_go;
    logic        vol_sel;
    logic        hold_act;
    logic [31:0] addr;
    logic [7:0]  vol_data;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  aw_a;
    logic [31:0] wdata;
    logic        wstrb0;
  } fbw_state_s;
endpackage

// ### hw/fbw_protect.sv
// Flash write protection: serial command check, status bits, AXI4-Lite view
// What this block does
// - Volatile read-parameter C0h and bank write 17h need no write latch.
// - Program or erase into the protected region is refused.
// - Full-array erase ignored unless all four protect bits are zero.
// - Status-write-disable at 0: status write allowed whatever the pin.
// - Disable at 1 and protect pin low: status bits locked, write ignored.
// - Disable at 1 and protect pin high: status write still takes effect.
// - Quad enable 0: protect and hold pins keep their control function.
// - Quad enable 1: protect and hold pins become data lines 2 and 3.
// - 64KB geometry: code 0 none, codes 1-11 protect 2^(code-1) blocks.
// - 64KB geometry: codes 12-15 protect 1536, 1792, 1920, 2048 blocks.
// - Top placement: protected run ends at the highest block.
// - Bottom placement: protected run starts at block zero.
// - 256KB geometry: code 0 none, codes 1-9 protect 2^(code-1) blocks.
// - 256KB geometry: codes 10-15 protect all 512 blocks.
// - Top/bottom select resets to top and can only move to bottom.
`include "fbw_map.svh"

module fbw_protect
  import fbw_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Serial link pins
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_si,
  input  wire logic        data_line_2_i,
  output      logic        data_line_2_o,
  output      logic        data_line_2_oe,
  input  wire logic        data_line_3_i,
  output      logic        data_line_3_o,
  output      logic        data_line_3_oe,
  // Array and volatile register requests
  output      logic        array_go,
  output      logic        array_erase_all,
  output      logic [31:0] array_addr,
  output      logic        cmd_refused,
  output      logic        vol_go,
  output      logic        vol_bank_sel,
  output      logic [7:0]  vol_data,
  output      logic        hold_active,
  // AXI4-Lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  fbw_state_s s_q;
  fbw_state_s s_d;
  fbw_kind_e  kind;
  logic       frame_end;
  logic       sck_rise;
  logic       wp_eff;
  logic       hit;

  // Number of protected blocks for a protect code
  function automatic logic [12:0] fbw_count(input logic [3:0] c,
                                            input logic       g);
    logic [12:0] n;
    n = 13'h0000;
    if (c != 4'h0)
      n = 13'h0001 << (c - 4'h1);
    if (g)
    begin
      if (c >= 4'hA)
        n = `FBW_BLK_256K;
      // Code 9 keeps 256 blocks on both placements
    end
    else
    begin
      unique case (c)
        4'hC:    n = 13'h0600;
        4'hD:    n = 13'h0700;
        4'hE:    n = 13'h0780;
        4'hF:    n = `FBW_BLK_64K;
        default: n = n;
      endcase
    end
    return n;
  endfunction

  // True when the address falls inside the protected run
  function automatic logic fbw_hit(input logic [31:0] a,
                                   input logic [3:0]  c,
                                   input logic        t,
                                   input logic        g);
    logic [12:0] blk;
    logic [12:0] n;
    logic [12:0] total;
    blk   = g ? {4'h0, a[26:18]} : {2'b00, a[26:16]};
    n     = fbw_count(c, g);
    total = g ? `FBW_BLK_256K : `FBW_BLK_64K;
    if (t)
      return blk < n;
    return (blk + n) >= total;
  endfunction

  // Opcode classes
  function automatic fbw_kind_e fbw_decode(input logic [7:0] op);
    unique case (op)
      `FBW_OP_WEL_SET:                       return FBW_K_WSET;
      `FBW_OP_WEL_CLR:                       return FBW_K_WCLR;
      `FBW_OP_STAT_WR:                       return FBW_K_STAT;
      `FBW_OP_FUNC_WR:                       return FBW_K_FUNC;
      `FBW_OP_ERASE_ALL_A, `FBW_OP_ERASE_ALL_B: return FBW_K_CHIP;
      `FBW_OP_VOL_PARAM, `FBW_OP_VOL_BANK:   return FBW_K_VOL;
      `FBW_OP_PP, `FBW_OP_PP4, `FBW_OP_PPQ, `FBW_OP_SE_A, `FBW_OP_SE_B,
      `FBW_OP_SE4, `FBW_OP_BE32, `FBW_OP_BE32_4, `FBW_OP_BE64,
      `FBW_OP_BE64_4:                        return FBW_K_PROG;
      default:                               return FBW_K_NONE;
    endcase
  endfunction

  // Link events seen from the synchronised pins
  assign sck_rise  = s_q.sck_s[1] & ~s_q.sck_p;
  assign frame_end = s_q.cs_s[1] & ~s_q.cs_p & (s_q.cnt >= `FBW_BITS_OP);
  assign kind      = fbw_decode(s_q.op);
  // In quad mode the protect pin is data, so hardware lock is off
  assign wp_eff    = s_q.qe | s_q.wp_s[1];
  assign hit       = fbw_hit(s_q.pay, s_q.bp, s_q.top_bottom_select, s_q.g256);

  // Next state
  always_comb
  begin
    s_d = s_q;
    // Two flops on every pin from the link side
    s_d.sck_s  = {s_q.sck_s[0], spi_sck};
    s_d.cs_s   = {s_q.cs_s[0], spi_cs_n};
    s_d.si_s   = {s_q.si_s[0], spi_si};
    s_d.wp_s   = {s_q.wp_s[0], data_line_2_i};
    s_d.hold_s = {s_q.hold_s[0], data_line_3_i};
    s_d.sck_p  = s_q.sck_s[1];
    s_d.cs_p   = s_q.cs_s[1];
    s_d.array_go  = 1'b0;
    s_d.erase_all = 1'b0;
    s_d.refused   = 1'b0;
    s_d.vol_go    = 1'b0;
    // Hold only acts while the pin is a control input
    s_d.hold_act = ~s_q.qe & ~s_q.hold_s[1];

    // Shift opcode then payload; extra bits past the address are dropped
    if (s_q.cs_s[1])
      s_d.cnt = 6'd0;
    else if (sck_rise && s_q.cnt < `FBW_BITS_ADDR)
    begin
      s_d.cnt = s_q.cnt + 6'd1;
      if (s_q.cnt < `FBW_BITS_OP)
        s_d.op = {s_q.op[6:0], s_q.si_s[1]};
      else
        s_d.pay = {s_q.pay[30:0], s_q.si_s[1]};
    end

    // Judge the command when chip select rises
    if (frame_end)
    begin
      s_d.last_op  = s_q.op;
      s_d.last_ok  = 1'b0;
      s_d.last_ref = 1'b0;
      unique case (kind)
        FBW_K_WSET: s_d.wel = 1'b1;
        FBW_K_WCLR: s_d.wel = 1'b0;
        FBW_K_VOL:
        begin
          // No latch needed for these two
          s_d.vol_go   = s_q.cnt >= `FBW_BITS_BYTE;
          s_d.vol_sel  = s_q.op == `FBW_OP_VOL_BANK;
          s_d.vol_data = s_q.pay[7:0];
          s_d.last_ok  = s_q.cnt >= `FBW_BITS_BYTE;
        end
        FBW_K_STAT:
        begin
          if (s_q.wel && (!s_q.status_write_disable || wp_eff))
          begin
            s_d.bp   = s_q.pay[`FBW_SB_BP_LO +: 4];
            s_d.qe   = s_q.pay[`FBW_SB_QE];
            s_d.status_write_disable = s_q.pay[`FBW_SB_STATUS_WRITE_DISABLE];
            s_d.wel  = 1'b0;
            s_d.last_ok = 1'b1;
          end
          else
            s_d.last_ref = 1'b1;
        end
        FBW_K_FUNC:
        begin
          // Select can be set but never cleared
          if (s_q.wel)
            s_d.top_bottom_select = s_q.top_bottom_select | s_q.pay[`FBW_FB_TBS];
          s_d.wel      = 1'b0;
          s_d.last_ok  = s_q.wel;
          s_d.last_ref = ~s_q.wel;
        end
        FBW_K_CHIP:
        begin
          if (s_q.wel && s_q.bp == 4'h0)
          begin
            s_d.erase_all = 1'b1;
            s_d.wel       = 1'b0;
            s_d.last_ok   = 1'b1;
          end
          else
          begin
            s_d.refused  = 1'b1;
            s_d.last_ref = 1'b1;
          end
        end
        FBW_K_PROG:
        begin
          // Short frames carry no usable address and are refused
          if (s_q.wel && !hit && s_q.cnt == `FBW_BITS_ADDR)
          begin
            s_d.array_go = 1'b1;
            s_d.addr     = s_q.pay;
            s_d.wel      = 1'b0;
            s_d.last_ok  = 1'b1;
          end
          else
          begin
            s_d.refused  = 1'b1;
            s_d.last_ref = 1'b1;
          end
        end
        default: s_d.last_ok = 1'b0;
      endcase
    end

    // AXI write: address and data taken in either order
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.aw_got  = 1'b1;
      s_d.awready = 1'b0;
      s_d.aw_a    = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.w_got  = 1'b1;
      s_d.wready = 1'b0;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `FBW_RESP_ERR;
      if (s_q.aw_a == `FBW_REG_GEOM)
      begin
        s_d.bresp = `FBW_RESP_OK;
        if (s_q.wstrb0)
          s_d.g256 = s_q.wdata[0];
      end
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // AXI read: answer one cycle after the address is taken
    if (s_axi_arvalid && s_q.arready)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = `FBW_RESP_OK;
      unique case (s_axi_araddr[3:0])
        `FBW_REG_STATUS:
          s_d.rdata = {24'h000000, s_q.status_write_disable, s_q.qe, s_q.bp, s_q.wel, 1'b0};
        `FBW_REG_FUNC: s_d.rdata = {30'h00000000, s_q.top_bottom_select, 1'b0};
        `FBW_REG_GEOM: s_d.rdata = {31'h00000000, s_q.g256};
        `FBW_REG_LAST:
          s_d.rdata = {22'h000000, s_q.last_ref, s_q.last_ok, s_q.last_op};
        default:
        begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = `FBW_RESP_ERR;
        end
      endcase
      if (s_axi_araddr[31:4] != 28'h0000000)
      begin
        s_d.rdata = 32'h00000000;
        s_d.rresp = `FBW_RESP_ERR;
      end
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
  end

  // State register; select, protect and hold pins idle high, clock low, so the link starts deselected
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q         <= '0;
      s_q.sck_s   <= 2'b00;
      s_q.cs_s    <= 2'b11;
      s_q.cs_p    <= 1'b1;
      s_q.wp_s    <= 2'b11;
      s_q.hold_s  <= 2'b11;
      s_q.bp      <= `FBW_RST_BP;
      s_q.g256    <= `FBW_RST_GEOM;
      s_q.last_op <= 8'h00;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs from the state flops; no read path, so data lines stay released
  assign data_line_2_o   = s_q.refused & 1'b0;
  assign data_line_2_oe  = s_q.refused & 1'b0;
  assign data_line_3_o   = s_q.refused & 1'b0;
  assign data_line_3_oe  = s_q.refused & 1'b0;
  assign array_go        = s_q.array_go;
  assign array_erase_all = s_q.erase_all;
  assign array_addr      = s_q.addr;
  assign cmd_refused     = s_q.refused;
  assign vol_go          = s_q.vol_go;
  assign vol_bank_sel    = s_q.vol_sel;
  assign vol_data        = s_q.vol_data;
  assign hold_active     = s_q.hold_act;
  assign s_axi_awready   = s_q.awready;
  assign s_axi_wready    = s_q.wready;
  assign s_axi_bvalid    = s_q.bvalid;
  assign s_axi_bresp     = s_q.bresp;
  assign s_axi_arready   = s_q.arready;
  assign s_axi_rvalid    = s_q.rvalid;
  assign s_axi_rresp     = s_q.rresp;
  assign s_axi_rdata     = s_q.rdata;

  // Checks on the protection decisions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  vol_no_latch_a: assert property (
    frame_end && kind == FBW_K_VOL && !s_q.wel
      && s_q.cnt >= `FBW_BITS_BYTE |=> vol_go)
    else $error("volatile write needed latch");
  prot_refuse_a: assert property (
    frame_end && kind == FBW_K_PROG && hit |=> cmd_refused && !array_go)
    else $error("program into protected area granted");
  chip_erase_a: assert property (
    array_erase_all |-> $past(s_q.bp) == 4'h0)
    else $error("full erase with protect bits set");
  stat_open_a: assert property (
    frame_end && kind == FBW_K_STAT && s_q.wel && !s_q.status_write_disable
      |=> s_q.bp == $past(s_q.pay[5:2]) && !s_q.wel)
    else $error("status write lost while unlocked");
  stat_lock_a: assert property (
    frame_end && kind == FBW_K_STAT && s_q.status_write_disable && !wp_eff
      |=> $stable(s_q.bp) && $stable(s_q.status_write_disable) && $stable(s_q.qe))
    else $error("locked status changed");
  stat_pinhi_a: assert property (
    frame_end && kind == FBW_K_STAT && s_q.wel && s_q.status_write_disable && wp_eff
      |=> s_q.status_write_disable == $past(s_q.pay[7]))
    else $error("status write ignored with pin high");
  quad_hold_a: assert property (
    s_q.qe ##1 s_q.qe |=> !hold_active)
    else $error("hold acted in quad mode");
  top_all_a: assert property (
    !s_q.g256 && s_q.bp == 4'hF |-> hit)
    else $error("all-block code left a hole");
  bot_256_a: assert property (
    s_q.g256 && s_q.top_bottom_select && s_q.bp == 4'h9
      |-> hit == (s_q.pay[26:18] < 9'h100))
    else $error("bottom code nine range wrong");
  tbs_otp_a: assert property (
    s_q.top_bottom_select |=> s_q.top_bottom_select)
    else $error("bottom select returned to top");

  prog_ok_c:  cover property (array_go);
  prog_ref_c: cover property (frame_end && kind == FBW_K_PROG && hit);
  stat_wr_c:  cover property (frame_end && kind == FBW_K_STAT && s_q.wel);
  erase_c:    cover property (array_erase_all);

endmodule

// ### tb/fbw_host_model.sv
// Serial host model that issues flash command frames on the link
module fbw_host_model
(
  // Link pins toward the device
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_si
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle link: clock parked low, select high
  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end

  // One frame MSB first, link clock 400 ns, runs only inside frames
  task automatic send(input logic [39:0] v, input int n);
    begin
      #7 spi_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
        spi_si = v[i];
        #200 spi_sck = 1'b1;
        #200 spi_sck = 1'b0;
      end
      #200 spi_cs_n = 1'b1;
      // No pull on the line, so never leave the last bit standing
      spi_si = ~spi_si;
      #800;
    end
  endtask

  // Whole frames only: opcode, opcode plus byte, opcode plus address
  task automatic op8(input logic [7:0] v);
    send({32'h0, v}, 8);
  endtask
  task automatic op16(input logic [15:0] v);
    send({24'h0, v}, 16);
  endtask
  task automatic op40(input logic [39:0] v);
    send(v, 40);
  endtask
endmodule

// ### tb/fbw_protect_tb.sv
// Bench for the flash write protection block with a behavioural model
module fbw_protect_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Design pins
  logic        sys_clk = 1'b0, rst_n = 1'b0;
  logic        spi_sck, spi_cs_n, spi_si;
  logic        data_line_2_i = 1'b1, data_line_3_i = 1'b1;
  logic        data_line_2_o, data_line_2_oe, data_line_3_o, data_line_3_oe;
  logic        array_go, array_erase_all, cmd_refused, vol_go;
  logic        vol_bank_sel, hold_active;
  logic [31:0] array_addr, s_axi_rdata;
  logic [7:0]  vol_data;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  // Pulse counters and model state
  logic [7:0]  n_go = 8'h0, n_er = 8'h0, n_rf = 8'h0, n_vol = 8'h0;
  int          e_go, e_er, e_rf, e_vol, e_g, e_tbs, e_wel, e_qe, e_status_write_disable;
  int          e_bp, fails, tests_run, seed = 32'hb80f;
  logic [31:0] e_addr = 32'h0;
  logic [8:0]  e_vv = 9'h0;
  logic [9:0]  e_lst = 10'h0;
  logic [7:0]  prog_ops [10] = '{8'h02, 8'h12, 8'h32, 8'h20, 8'hD7,
                                8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC};

  fbw_protect fbw_protect_i (
    .sys_clk, .rst_n, .spi_sck, .spi_cs_n, .spi_si,
    .data_line_2_i, .data_line_2_o, .data_line_2_oe,
    .data_line_3_i, .data_line_3_o, .data_line_3_oe,
    .array_go, .array_erase_all, .array_addr, .cmd_refused, .vol_go,
    .vol_bank_sel, .vol_data, .hold_active,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  fbw_host_model fbw_host_model_i (.spi_sck, .spi_cs_n, .spi_si);

  // System clock, 50 ns
  initial forever #25 sys_clk = ~sys_clk;

  // Count the one-cycle decision pulses; outputs are unknown before the
  // first reset edge, so counting waits for reset release
  always @(posedge sys_clk)
  begin
    if (rst_n)
    begin
      n_go <= n_go + {7'h0, array_go};
      n_er <= n_er + {7'h0, array_erase_all};
      n_rf <= n_rf + {7'h0, cmd_refused};
      n_vol <= n_vol + {7'h0, vol_go};
    end
  end

  task automatic results();
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task automatic give_up();
    begin
      fails++;
      results();
    end
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    begin
      tests_run++;
      if (g !== e)
      begin
        fails++;
        $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // Register bus write; both channels offered together
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    logic got;
    begin
      got = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (50)
      begin
        @(posedge sys_clk);
        if (s_axi_awready === 1'b1)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1)
        begin
          got = 1'b1;
          break;
        end
      end
      s_axi_bready <= 1'b0;
      if (!got)
        give_up();
      chk(s_axi_bresp, er);
    end
  endtask

  // Register bus read with compare of response and data
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    logic got;
    begin
      got = 1'b0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      repeat (50)
      begin
        @(posedge sys_clk);
        if (s_axi_arready === 1'b1)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1)
        begin
          got = 1'b1;
          break;
        end
      end
      s_axi_rready <= 1'b0;
      if (!got)
        give_up();
      chk({s_axi_rresp, s_axi_rdata}, {er, ed});
    end
  endtask

  // Blocks covered by a protect code in the current geometry
  function automatic int nblk(input int c);
    if (c == 0)
      return 0;
    if (e_g != 0)
      return (c >= 10) ? 512 : 1 << (c - 1);
    if (c >= 12)
      return (c == 15) ? 2048 : 2048 - (512 >> (c - 12));
    return 1 << (c - 1);
  endfunction

  function automatic bit prot(input logic [31:0] a);
    int tot;
    int blk;
    tot = (e_g != 0) ? 512 : 2048;
    blk = (e_g != 0) ? a[26:18] : a[26:16];
    return (e_tbs != 0) ? blk < nblk(e_bp) : blk >= tot - nblk(e_bp);
  endfunction

  // Model of what one frame should do; e_lst is the last-command word
  task automatic exp_fr(input logic [7:0] op, input logic [31:0] a);
    e_lst = {2'b10, op};
    case (op)
      8'h06, 8'h04:
      begin
        e_wel = (op == 8'h06);
        e_lst = {2'b00, op};
      end
      8'h01:
        if (e_wel != 0 && (e_status_write_disable == 0 || data_line_2_i || e_qe != 0))
        begin
          e_status_write_disable = a[7];
          e_qe = a[6];
          e_bp = a[5:2];
          e_wel = 0;
          e_lst = {2'b01, op};
        end
      8'h42:
        if (e_wel != 0)
        begin
          e_tbs = e_tbs | a[1];
          e_wel = 0;
          e_lst = {2'b01, op};
        end
      8'hC0, 8'h17:
      begin
        e_vol++;
        e_vv = {op == 8'h17, a[7:0]};
        e_lst = {2'b01, op};
      end
      8'hC7, 8'h60:
        if (e_wel != 0 && e_bp == 0)
        begin
          e_er++;
          e_wel = 0;
          e_lst = {2'b01, op};
        end
        else
          e_rf++;
      default:
        if (e_wel != 0 && !prot(a))
        begin
          e_go++;
          e_addr = a;
          e_wel = 0;
          e_lst = {2'b01, op};
        end
        else
          e_rf++;
    endcase
  endtask

  // Send one frame, then compare pulses, outputs and status
  task automatic fr(input logic [7:0] op, input logic [31:0] a);
    begin
      exp_fr(op, a);
      if (op inside {8'h06, 8'h04, 8'hC7, 8'h60})
        fbw_host_model_i.op8(op);
      else if (op inside {8'h01, 8'h42, 8'hC0, 8'h17})
        fbw_host_model_i.op16({op, a[7:0]});
      else
        fbw_host_model_i.op40({op, a});
      chk({n_go, n_er, n_rf, n_vol, vol_bank_sel, vol_data}, {e_go[7:0], e_er[7:0], e_rf[7:0], e_vol[7:0], e_vv});
      chk(array_addr, e_addr);
      axi_rd(32'h0, {e_status_write_disable[0], e_qe[0], e_bp[3:0], e_wel[0], 1'b0}, 2'b00);
      axi_rd(32'h4, {e_tbs[0], 1'b0}, 2'b00);
      axi_rd(32'hC, {22'h0, e_lst}, 2'b00);
    end
  endtask

  // Main sequence
  initial
  begin
    int n;
    int tot;
    int blk;
    int r;
    logic [31:0] a;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    axi_rd(32'h0, 32'h0, 2'b00);
    axi_rd(32'h4, 32'h0, 2'b00);
    axi_wr(32'h0, 32'h1, 4'hF, 2'b10);
    axi_wr(32'h8, 32'h1, 4'h0, 2'b00);
    axi_rd(32'h8, 32'h0, 2'b00);
    axi_rd(32'h10, 32'h0, 2'b10);
    fr(8'hC0, 32'h5A);
    fr(8'h17, 32'hA5);
    fr(8'h02, 32'h0);
    fr(8'h06, 0);
    fr(8'hC7, 0);
    // Latch cleared again before use: program must be refused
    fr(8'h06, 0);
    fr(8'h04, 0);
    fr(8'hD8, 32'h0);
    // Every code, both placements, both geometries, edge blocks
    for (int t = 0; t < 2; t++)
    begin
      if (t == 1)
      begin
        fr(8'h06, 0);
        fr(8'h42, 32'h2);
        fr(8'h06, 0);
        fr(8'h42, 32'h0);
      end
      for (int g = 0; g < 2; g++)
      begin
        axi_wr(32'h8, g, 4'hF, 2'b00);
        axi_rd(32'h8, g, 2'b00);
        e_g = g;
        for (int c = 0; c < 16; c++)
        begin
          fr(8'h06, 0);
          fr(8'h01, c << 2);
          tot = (g != 0) ? 512 : 2048;
          n = nblk(c);
          r = $random(seed);
          blk = {r} % tot;
          if (n > 0 && n < tot)
            blk = (t != 0) ? n - c % 2 : tot - n - c % 2;
          a = (g != 0) ? {5'h0, blk[8:0], r[17:0]} : {5'h0, blk[10:0], r[15:0]};
          fr(8'h06, 0);
          fr(prog_ops[c % 10], a);
          if (c == 5)
          begin
            fr(8'h06, 0);
            fr(8'h60, 0);
          end
        end
      end
    end
    // Hardware lock of the status byte by the protect pin
    @(posedge sys_clk);
    data_line_2_i <= 1'b0;
    fr(8'h06, 0);
    fr(8'h01, 32'h80);
    fr(8'h06, 0);
    fr(8'h01, 32'h3C);
    @(posedge sys_clk);
    data_line_2_i <= 1'b1;
    fr(8'h06, 0);
    fr(8'h01, 32'hC4); // Pins driven here, never tied
    @(posedge sys_clk);
    data_line_2_i <= 1'b0;
    data_line_3_i <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(hold_active, 1'b0);
    fr(8'h06, 0);
    fr(8'h01, 32'h00);
    repeat (4) @(posedge sys_clk);
    chk(hold_active, 1'b1);
    chk({data_line_2_oe, data_line_3_oe, data_line_2_o, data_line_3_o}, 4'h0);
    results();
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    give_up();
  end
endmodule
